/* core/ulc_pkg.sv */
// Package for the UART line configuration block: register map, field layout, states.
// Assumes a single 40 MHz clock domain and an AHB-Lite register bus.
`default_nettype none
package ulc_pkg;
   localparam logic [7:0] ULC_OFS_CFG = 8'h00;
   localparam logic [7:0] ULC_OFS_TXDATA = 8'h04;
   localparam logic [7:0] ULC_OFS_RXDATA = 8'h08;
   localparam logic [7:0] ULC_OFS_STATUS = 8'h0c;
   localparam logic [31:0] ULC_CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] ULC_CFG_WMASK = 32'h0001_f7ff;
   localparam int ULC_STS_RXCNT_POS = 0;
   localparam int ULC_STS_TXCNT_POS = 8;
   localparam int ULC_STS_BUSY_POS = 16;
   localparam int ULC_STS_ERR_POS = 24;
   localparam logic [3:0] ULC_TICKS_LAST = 4'hf;
   localparam logic [3:0] ULC_IR_PULSE_TICKS = 4'h3;
   localparam logic [1:0] ULC_PAR_EVEN = 2'h0;
   localparam logic [1:0] ULC_PAR_ODD = 2'h1;

   typedef struct packed {
      logic [14:0] rsvd_hi;
      logic tx_pad_enable;
      logic [3:0] rx_sample_pos;
      logic rsvd_11;
      logic infrared_out_pol;
      logic infrared_in_pol;
      logic infrared_select;
      logic echo_en;
      logic remote_loop;
      logic local_loop;
      logic rx_swap;
      logic tx_swap;
      logic [1:0] parity_mode;
      logic two_stop;
   } ulc_cfg_s;

   typedef enum logic [4:0] {
      TX_IDLE = 5'b00001, TX_START = 5'b00010, TX_DATA = 5'b00100, TX_PAR = 5'b01000, TX_STOP = 5'b10000
   } ulc_tx_e;

   typedef enum logic [4:0] {
      RX_IDLE = 5'b00001, RX_START = 5'b00010, RX_DATA = 5'b00100, RX_PAR = 5'b01000, RX_STOP = 5'b10000
   } ulc_rx_e;
endpackage : ulc_pkg
`default_nettype wire

/* core/ulc_top.sv */
// UART line configuration, loopback and infrared logic with word FIFOs.
// Assumes inputs synchronous to mclk_i; this slave's hreadyout_o is the bus hready.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module ulc_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Sync reset
   input wire logic in_valid_i, // Write request
   input wire logic [WIDTH-1:0] in_data_i, // Write data
   output logic in_ready_o, // Space free
   output logic out_valid_o, // Data present
   output logic [WIDTH-1:0] out_data_o, // Head word
   input wire logic out_ready_i, // Pop request
   output logic [$clog2(DEPTH+1)-1:0] count_o // Words held
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);
   if (DEPTH < 2 || WIDTH < 1) begin : g_chk
      $error("ulc_fifo: DEPTH must be at least 2");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr;
   logic do_wr, do_rd;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      return (p == AW'(DEPTH-1)) ? '0 : p + 1'b1;
   endfunction : bump

   assign in_ready_o = (count_o != CW'(DEPTH));
   assign out_valid_o = (count_o != '0);
   assign out_data_o = mem[rd_ptr];
   assign do_wr = in_valid_i & in_ready_o;
   assign do_rd = out_ready_i & out_valid_o;

   always_ff @(posedge clk_i) begin
      if (do_wr) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count_o <= '0;
      end else begin
         if (do_wr) wr_ptr <= bump(wr_ptr);
         if (do_rd) rd_ptr <= bump(rd_ptr);
         count_o <= count_o + CW'(do_wr) - CW'(do_rd);
      end
   end
endmodule : ulc_fifo

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Sample each rx bit at programmed position
// - IR transmit output polarity follows out-pol bit
// - IR receive input polarity follows in-pol bit
// - Mode bit picks line or infrared signalling
// - Echo copies rx onto tx, still receives
// - Remote loop: rx to tx, receiver off
// - Local loop feeds tx into receiver too
// - Rx bytes packed; optional swap to big-endian
// - Tx words unpacked bytewise; optional swap
// - Parity: even, odd, none; reserved
// - One or two stop bits
module ulc_top import ulc_pkg::*; #(
   parameter int CLKS_PER_TICK = 22,
   parameter int FIFO_DEPTH = 32
) (
   input wire logic mclk_i, // 40 MHz clock
   input wire logic sys_rst_i, // Sync reset, high
   input wire logic hsel_i, // AHB select
   input wire logic [31:0] haddr_i, // AHB address
   input wire logic [1:0] htrans_i, // AHB transfer type
   input wire logic hwrite_i, // AHB write
   input wire logic [2:0] hsize_i, // AHB size, word only
   input wire logic [31:0] hwdata_i, // AHB write data
   input wire logic hready_i, // AHB bus ready
   output logic hreadyout_o, // AHB slave ready
   output logic hresp_o, // AHB response, OKAY
   output logic [31:0] hrdata_o, // AHB read data
   input wire logic rxd_i, // Serial line in
   input wire logic ir_rx_i, // Infrared receiver in
   output logic txd_o, // Serial line out
   output logic ir_tx_o // Infrared emitter out
);
   if (CLKS_PER_TICK < 1 || CLKS_PER_TICK > 65535 || FIFO_DEPTH < 2 || FIFO_DEPTH > 255) begin : g_chk
      $error("ulc_top: parameter out of range");
   end
   localparam int CW = $clog2(FIFO_DEPTH+1);

   ulc_cfg_s cfg;
   logic [15:0] div_cnt;
   logic tick;
   logic dp_valid, dp_write;
   logic [7:0] dp_addr;
   logic tx_in_ready, tx_valid, tx_pop, rx_valid, rx_pop, rx_in_ready;
   logic [31:0] tx_head, rx_head;
   logic [CW-1:0] tx_cnt, rx_cnt;
   logic [2:0] err; // overrun, framing, parity
   logic [2:0] next_err_set;
   logic tx_busy, tx_pop_q, rx_line;

   function automatic logic par_of(input logic [7:0] b, input logic [1:0] mode);
      return (mode == ULC_PAR_ODD) ? ~^b : ^b;
   endfunction : par_of

   function automatic logic [31:0] swap_word(input logic [31:0] w, input logic en);
      return en ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
   endfunction : swap_word

   ////////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait except a write into a full tx FIFO
   logic take, wr_fire;
   assign take = hsel_i & htrans_i[1] & hready_i;
   assign hreadyout_o = ~(dp_valid & dp_write & (dp_addr == ULC_OFS_TXDATA) & ~tx_in_ready);
   assign hresp_o = 1'b0;
   assign wr_fire = dp_valid & dp_write & hreadyout_o;
   assign tx_pop = 1'b0 | tx_pop_q;
   assign rx_pop = dp_valid & ~dp_write & (dp_addr == ULC_OFS_RXDATA);

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_addr <= '0;
      end else if (hready_i) begin
         dp_valid <= take;
         dp_write <= hwrite_i;
         dp_addr <= haddr_i[7:0];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         cfg <= ULC_CFG_RESET;
      end else if (wr_fire && dp_addr == ULC_OFS_CFG) begin
         cfg <= hwdata_i & ULC_CFG_WMASK;
      end
   end

   // Hardware set wins over a write-one clear
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         err <= '0;
      end else if (wr_fire && dp_addr == ULC_OFS_STATUS) begin
         err <= (err & ~hwdata_i[ULC_STS_ERR_POS +: 3]) | next_err_set;
      end else begin
         err <= err | next_err_set;
      end
   end

   always_comb begin
      hrdata_o = '0;
      if (dp_valid && !dp_write) begin
         case (dp_addr)
            ULC_OFS_CFG: hrdata_o = cfg;
            ULC_OFS_RXDATA: hrdata_o = rx_valid ? rx_head : '0;
            ULC_OFS_STATUS: begin
               hrdata_o[ULC_STS_RXCNT_POS +: 8] = 8'(rx_cnt);
               hrdata_o[ULC_STS_TXCNT_POS +: 8] = 8'(tx_cnt);
               hrdata_o[ULC_STS_BUSY_POS] = tx_busy;
               hrdata_o[ULC_STS_ERR_POS +: 3] = err;
            end
            default: hrdata_o = '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Oversampling tick, 16 per bit
   assign tick = (div_cnt == 16'(CLKS_PER_TICK - 1));
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || tick) div_cnt <= '0;
      else div_cnt <= div_cnt + 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Transmitter: one word drained a byte at a time
   ulc_tx_e tx_st;
   logic [3:0] tx_ph;
   logic [2:0] tx_idx;
   logic [1:0] tx_bsel;
   logic tx_stop_idx, tx_serial, bit_end;
   logic [31:0] tx_word;
   logic [7:0] tx_byte;

   ulc_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .clk_i(mclk_i), .rst_i(sys_rst_i),
      .in_valid_i(dp_valid & dp_write & (dp_addr == ULC_OFS_TXDATA)), .in_data_i(hwdata_i),
      .in_ready_o(tx_in_ready), .out_valid_o(tx_valid), .out_data_o(tx_head),
      .out_ready_i(tx_pop), .count_o(tx_cnt));

   assign tx_pop_q = tx_valid & ~tx_busy;
   assign bit_end = tick & (tx_ph == ULC_TICKS_LAST);
   assign tx_byte = tx_word[8*tx_bsel +: 8];

   always_comb begin
      case (tx_st)
         TX_START: tx_serial = 1'b0;
         TX_DATA: tx_serial = tx_byte[tx_idx];
         TX_PAR: tx_serial = par_of(tx_byte, cfg.parity_mode);
         default: tx_serial = 1'b1;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) tx_ph <= '0;
      else if (tick) tx_ph <= tx_ph + 4'h1;
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         tx_st <= TX_IDLE;
         tx_busy <= 1'b0;
         tx_word <= '0;
         tx_idx <= '0;
         tx_bsel <= '0;
         tx_stop_idx <= 1'b0;
      end else begin
         if (tx_pop_q) begin
            tx_busy <= 1'b1;
            tx_word <= swap_word(tx_head, cfg.tx_swap);
            tx_bsel <= '0;
         end
         if (bit_end) begin
            case (tx_st)
               TX_IDLE: if (tx_busy) tx_st <= TX_START;
               TX_START: begin
                  tx_st <= TX_DATA;
                  tx_idx <= '0;
               end
               TX_DATA: begin
                  tx_idx <= tx_idx + 3'h1;
                  if (tx_idx == 3'h7) begin
                     tx_st <= cfg.parity_mode[1] ? TX_STOP : TX_PAR;
                     tx_stop_idx <= 1'b0;
                  end
               end
               TX_PAR: begin
                  tx_st <= TX_STOP;
                  tx_stop_idx <= 1'b0;
               end
               TX_STOP: begin
                  tx_stop_idx <= 1'b1;
                  if (tx_stop_idx == cfg.two_stop) begin
                     tx_st <= TX_IDLE;
                     tx_bsel <= tx_bsel + 2'h1;
                     if (tx_bsel == 2'h3) tx_busy <= 1'b0;
                  end
               end
               default: tx_st <= TX_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Line output: echo and remote loop replace own data with incoming line
   logic line_out, ir_pulse;
   assign line_out = (cfg.remote_loop | cfg.echo_en) ? rx_line : tx_serial;
   assign ir_pulse = ~line_out & (tx_ph < ULC_IR_PULSE_TICKS);

   // A disabled pad holds the line idle
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         txd_o <= 1'b1;
         ir_tx_o <= 1'b0;
      end else begin
         txd_o <= ~cfg.tx_pad_enable | cfg.infrared_select | line_out;
         ir_tx_o <= cfg.infrared_out_pol ^ (cfg.tx_pad_enable & cfg.infrared_select & ir_pulse);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Receiver: bytes packed into words, pushed whole
   ulc_rx_e rx_st;
   logic rx_src, rx_sample, rx_end, rx_push;
   logic [3:0] rx_ph;
   logic [2:0] rx_idx;
   logic [1:0] rx_bsel;
   logic [7:0] rx_sh;
   logic [31:0] rx_asm, rx_word;

   always_comb begin
      if (cfg.local_loop) rx_src = tx_serial;
      else if (cfg.infrared_select) rx_src = ~(ir_rx_i ^ cfg.infrared_in_pol);
      else rx_src = rxd_i;
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) rx_line <= 1'b1;
      else rx_line <= rx_src;
   end

   assign rx_sample = tick & (rx_ph == cfg.rx_sample_pos);
   assign rx_end = tick & (rx_ph == ULC_TICKS_LAST);

   always_comb begin
      next_err_set = '0;
      next_err_set[2] = rx_push & ~rx_in_ready;
      next_err_set[1] = (rx_st == RX_STOP) & rx_sample & ~rx_line;
      next_err_set[0] = (rx_st == RX_PAR) & rx_sample & (rx_line != par_of(rx_sh, cfg.parity_mode));
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rx_st <= RX_IDLE;
         rx_ph <= '0;
         rx_idx <= '0;
         rx_sh <= '0;
      end else if (cfg.remote_loop) begin
         rx_st <= RX_IDLE;
      end else begin
         if (tick) rx_ph <= rx_ph + 4'h1;
         case (rx_st)
            RX_IDLE: if (!rx_line) begin
               rx_st <= RX_START;
               rx_ph <= '0;
            end
            RX_START: if (rx_sample && rx_line) rx_st <= RX_IDLE;
               else if (rx_end) begin
                  rx_st <= RX_DATA;
                  rx_idx <= '0;
               end
            RX_DATA: begin
               if (rx_sample) rx_sh <= {rx_line, rx_sh[7:1]};
               if (rx_end) begin
                  rx_idx <= rx_idx + 3'h1;
                  if (rx_idx == 3'h7) rx_st <= cfg.parity_mode[1] ? RX_STOP : RX_PAR;
               end
            end
            RX_PAR: if (rx_end) rx_st <= RX_STOP;
            RX_STOP: if (rx_sample) rx_st <= RX_IDLE;
            default: rx_st <= RX_IDLE;
         endcase
      end
   end

   // Partial words wait for their remaining bytes
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rx_bsel <= '0;
         rx_asm <= '0;
         rx_push <= 1'b0;
         rx_word <= '0;
      end else begin
         rx_push <= 1'b0;
         if (rx_st == RX_STOP && rx_sample && !cfg.remote_loop) begin
            rx_asm[8*rx_bsel +: 8] <= rx_sh;
            rx_bsel <= rx_bsel + 2'h1;
            if (rx_bsel == 2'h3) begin
               rx_push <= 1'b1;
               rx_word <= swap_word({rx_sh, rx_asm[23:0]}, cfg.rx_swap);
            end
         end
      end
   end

   ulc_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .clk_i(mclk_i), .rst_i(sys_rst_i),
      .in_valid_i(rx_push), .in_data_i(rx_word),
      .in_ready_o(rx_in_ready), .out_valid_o(rx_valid), .out_data_o(rx_head),
      .out_ready_i(rx_pop), .count_o(rx_cnt));

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_stop_last;
      (tx_st == TX_STOP) && bit_end && (tx_stop_idx == cfg.two_stop);
   endsequence
   sequence s_back_idle;
      ##1 (tx_st == TX_IDLE);
   endsequence

   chk_rx_sample_pos: assert property (rx_st == RX_DATA && rx_sample && !cfg.remote_loop |=>
      rx_sh[7] == $past(rx_line))
      else $error("rx sampled off position");
   chk_ir_tx_idle: assert property (cfg.infrared_select && !ir_pulse ##1 $stable(cfg)
      |-> ir_tx_o == cfg.infrared_out_pol)
      else $error("ir tx idle level wrong");
   chk_ir_rx_pol: assert property (cfg.infrared_select && !cfg.local_loop && ir_rx_i != cfg.infrared_in_pol
      |=> !rx_line)
      else $error("infrared_in_pol wrong");
   chk_line_idle_ir: assert property (cfg.infrared_select [*2] |-> txd_o)
      else $error("line driven in infrared_select");
   chk_echo_copy: assert property (cfg.echo_en && cfg.tx_pad_enable && !cfg.infrared_select ##1 $stable(cfg)
      |-> txd_o == $past(rx_line))
      else $error("echo not copied");
   chk_remote_rx_off: assert property (cfg.remote_loop |=> rx_st == RX_IDLE && !rx_push)
      else $error("receiver active in remote loop");
   chk_local_feed: assert property (cfg.local_loop |=> rx_line == $past(tx_serial))
      else $error("local loop not fed");
   chk_no_par_state: assert property (cfg.parity_mode[1] && tx_st == TX_DATA |=> tx_st != TX_PAR)
      else $error("parity sent when disabled");
   chk_stop_end: assert property (s_stop_last |-> s_back_idle)
      else $error("stop count wrong");
   chk_cfg_reset: assert property ($rose(!sys_rst_i) |-> cfg == ULC_CFG_RESET)
      else $error("config not zero after reset");
endmodule : ulc_top
`default_nettype wire

/* bench/ulc_peer.sv */
// Far-side serial device: sends framed characters on the line or infrared input
// and decodes what the block sends. Assumes 16 clocks per bit (one clock per tick).
`default_nettype none
module ulc_peer (
   input wire logic clk_i, // Block clock
   input wire logic txd_i, // Block serial out
   input wire logic has_par_i, // Expect a parity bit
   output logic rxd_o, // Block serial in, idles high
   output logic ir_o // Block infrared in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got_q[$];
   logic par_q[$];
   int cyc = 0;
   int last = 0;
   int period = 0;

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rxd_o = 1'b1;
      ir_o = 1'b0;
   end
   always @(posedge clk_i) cyc <= cyc + 1;

   // Start-to-start spacing shows the stop-bit count of back-to-back frames
   initial begin : rx_side
      logic [7:0] b;
      logic p;
      forever begin
         @(negedge txd_i);
         period = cyc - last;
         last = cyc;
         repeat (8) @(posedge clk_i);
         for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge clk_i);
            b[i] = txd_i;
         end
         p = 1'b0;
         if (has_par_i) begin
            repeat (16) @(posedge clk_i);
            p = txd_i;
         end
         repeat (16) @(posedge clk_i);
         got_q.push_back(b);
         par_q.push_back(p);
      end
   end

   task automatic send(input logic [7:0] d, input logic [1:0] pm, input logic ts, input logic ir, input logic pol);
      logic [11:0] f;
      int n;
      f = pm[1] ? {3'b111, d, 1'b0} : {2'b11, pm[0] ? ~^d : ^d, d, 1'b0};
      n = (pm[1] ? 10 : 11) + (ts ? 1 : 0);
      for (int i = 0; i < n; i++) begin
         for (int t = 0; t < 16; t++) begin
            @(posedge clk_i);
            rxd_o <= ir | f[i];
            ir_o <= (ir && !f[i] && t < 3) ? ~pol : pol;
         end
      end
   endtask : send

   task automatic idle(input logic pol);
      @(posedge clk_i);
      ir_o <= pol;
   endtask : idle
endmodule : ulc_peer
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for ulc_top: AHB-Lite master tasks, one task per scenario.
// Assumes the serial peer model and CLKS_PER_TICK of 1, so a bit is 16 clocks.
`default_nettype none
module testbench import ulc_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] pad_on = 32'h0001_0000;
   localparam logic [31:0] samp7 = 32'h0000_7000;
   logic mclk_i, sys_rst_i, hsel, hwrite, hrdy, hresp, txd, ir_tx, rxd, ir_rx, has_par;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata;
   int fail_count = 0;
   int total_checks = 0;

   ulc_top #(.CLKS_PER_TICK(1), .FIFO_DEPTH(32)) dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
      .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata), .rxd_i(rxd), .ir_rx_i(ir_rx), .txd_o(txd),
      .ir_tx_o(ir_tx));
   ulc_peer peer (.clk_i(mclk_i), .txd_i(txd), .has_par_i(has_par), .rxd_o(rxd), .ir_o(ir_rx));

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask : chk

   task automatic hang(input string m);
      chk(32'h0, 32'h1, m);
      end_sim();
   endtask : hang

   function automatic logic [31:0] bswap(input logic [31:0] w);
      return {w[7:0], w[15:8], w[23:16], w[31:24]};
   endfunction : bswap

   task automatic wait_rdy();
      int n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (hrdy !== 1'b1 && n < 200);
      if (hrdy !== 1'b1) hang("bus stall");
   endtask : wait_rdy

   // Address phase held until hready, then data phase until hready
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string m);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      chk(r, exp, m);
      chk({31'h0, hresp}, 32'h0, "response not okay");
   endtask : rdc

   task automatic wait_tx(input int n);
      for (int i = 0; i < 4000 && peer.got_q.size() < n; i++) @(posedge mclk_i);
      if (peer.got_q.size() < n) hang("no serial output");
      repeat (32) @(posedge mclk_i);
   endtask : wait_tx

   task automatic rx_word(input logic [31:0] exp);
      logic [31:0] r;
      int i = 0;
      do begin
         xfer(1'b0, ULC_OFS_STATUS, 32'h0, r);
         i++;
      end while (r[7:0] == 8'h0 && i < 400);
      if (r[7:0] == 8'h0) hang("no rx word");
      rdc(ULC_OFS_RXDATA, exp, "rx word");
   endtask : rx_word

   task automatic burst(input logic [31:0] w, input logic [1:0] pm, input logic ts, input logic ir, input logic pol);
      peer.got_q.delete();
      peer.par_q.delete();
      for (int k = 0; k < 4; k++) peer.send(w[8*k +: 8], pm, ts, ir, pol);
   endtask : burst

   ////////////////////////////////////////////////////////////////////////////
   task automatic s_regs();
      rdc(ULC_OFS_CFG, ULC_CFG_RESET, "cfg reset");
      chk({31'h0, txd}, 32'h1, "txd idle");
      rdc(ULC_OFS_STATUS, 32'h0, "status reset");
      // Remote loop in the all-ones value keeps the receiver quiet
      wr(ULC_OFS_CFG, 32'hffff_ffff);
      rdc(ULC_OFS_CFG, ULC_CFG_WMASK, "cfg readback");
      rdc(8'h40, 32'h0, "unmapped read");
      wr(ULC_OFS_CFG, 32'h0);
   endtask : s_regs

   task automatic s_tx();
      logic [31:0] w;
      logic [7:0] b;
      logic [1:0] pm;
      logic ts;
      int p;
      for (int m = 0; m < 6; m++) begin
         pm = 2'(m / 2);
         ts = m[0];
         w = 32'h5a3c_81c3 + 32'(m);
         has_par <= !pm[1];
         wr(ULC_OFS_CFG, pad_on | samp7 | {28'h0, ts, pm, ts});
         peer.got_q.delete();
         peer.par_q.delete();
         wr(ULC_OFS_TXDATA, w);
         wait_tx(4);
         for (int k = 0; k < 4; k++) begin
            b = 8'((ts ? bswap(w) : w) >> (8 * k));
            chk({24'h0, peer.got_q[k]}, {24'h0, b}, "tx byte");
            if (!pm[1]) chk({31'h0, peer.par_q[k]}, {31'h0, pm[0] ? ~^b : ^b}, "tx parity");
         end
         p = (10 + (pm[1] ? 0 : 1) + (ts ? 1 : 0)) * 16;
         chk({31'h0, peer.period >= p && peer.period <= p + 16}, 32'h1, "frame length");
      end
      has_par <= 1'b1;
   endtask : s_tx

   task automatic s_rx();
      logic sw;
      for (int s = 0; s < 2; s++) begin
         sw = s[0];
         wr(ULC_OFS_CFG, samp7 | {27'h0, sw, 2'h0, sw, sw});
         burst(32'h4433_2211, {1'b0, sw}, sw, 1'b0, 1'b0);
         rx_word(sw ? 32'h1122_3344 : 32'h4433_2211);
      end
   endtask : s_rx

   task automatic s_loops();
      wr(ULC_OFS_CFG, pad_on | samp7 | 32'h20);
      peer.got_q.delete();
      wr(ULC_OFS_TXDATA, 32'hdead_beef);
      wait_tx(4);
      chk({24'h0, peer.got_q[3]}, 32'hde, "local line");
      rx_word(32'hdead_beef);
      wr(ULC_OFS_CFG, pad_on | samp7 | 32'h80);
      burst(32'h0f1e_2d3c, 2'h0, 1'b0, 1'b0, 1'b0);
      wait_tx(4);
      chk({24'h0, peer.got_q[0]}, 32'h3c, "echo line");
      rx_word(32'h0f1e_2d3c);
      wr(ULC_OFS_CFG, pad_on | samp7 | 32'h40);
      burst(32'h7788_99aa, 2'h0, 1'b0, 1'b0, 1'b0);
      wait_tx(4);
      chk({24'h0, peer.got_q[1]}, 32'h99, "remote line");
      rdc(ULC_OFS_RXDATA, 32'h0, "remote rx off");
   endtask : s_loops

   task automatic s_ir_tx();
      logic pol;
      int act;
      int low;
      for (int k = 0; k < 2; k++) begin
         pol = k[0];
         act = 0;
         low = 0;
         wr(ULC_OFS_CFG, pad_on | 32'h100 | {21'h0, pol, 10'h0});
         wr(ULC_OFS_TXDATA, 32'h0);
         repeat (1000) begin
            @(posedge mclk_i);
            act += (ir_tx === ~pol) ? 1 : 0;
            low += (txd !== 1'b1) ? 1 : 0;
         end
         // Four zero bytes, even parity: ten zero bits each
         chk(32'(act), 32'(40 * ULC_IR_PULSE_TICKS), "ir pulses");
         chk(32'(low), 32'h0, "line quiet in ir");
      end
   endtask : s_ir_tx

   task automatic s_ir_rx();
      logic pol;
      for (int k = 0; k < 2; k++) begin
         pol = k[0];
         // Idle level moves while line mode is selected, so no false start
         wr(ULC_OFS_CFG, 32'h1000 | {22'h0, pol, 9'h0});
         peer.idle(pol);
         wr(ULC_OFS_CFG, 32'h1100 | {22'h0, pol, 9'h0});
         burst(32'hc3a5_0ff0, 2'h0, 1'b0, 1'b1, pol);
         rx_word(32'hc3a5_0ff0);
      end
   endtask : s_ir_rx

   task automatic s_pad_off();
      int low = 0;
      wr(ULC_OFS_CFG, samp7);
      wr(ULC_OFS_TXDATA, 32'h0);
      repeat (1000) begin
         @(posedge mclk_i);
         low += (txd !== 1'b1) ? 1 : 0;
      end
      chk(32'(low), 32'h0, "pad disabled");
   endtask : s_pad_off

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end

   initial begin
      sys_rst_i = 1'b1;
      hsel = 1'b0;
      htrans = 2'h0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      has_par = 1'b1;
      repeat (2) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      @(posedge mclk_i);
      s_regs();
      s_tx();
      s_rx();
      s_loops();
      s_ir_tx();
      s_ir_rx();
      s_pad_off();
      end_sim();
   end
endmodule : testbench
`default_nettype wire
